// ===== core/qmp_pkg.sv
// qmp_pkg: constants and types of the counter and pwm block
package qmp_pkg;
	// ****************
	// timing
	// ****************
	localparam int CLK_HZ = 40_000_000;
	localparam int MARK_WIN_US = 50;
	localparam int MARK_WIN_CYC = MARK_WIN_US * (CLK_HZ / 1_000_000);
	localparam int DUTY_FULL = 32_000;
	localparam int DUTY_SCALE = CLK_HZ / DUTY_FULL;
	// ****************
	// register byte offsets
	// ****************
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_LADDER  = 8'h04;
	localparam logic [7:0] OFS_WRAP1   = 8'h08;
	localparam logic [7:0] OFS_WRAP2   = 8'h0C;
	localparam logic [7:0] OFS_PRESET1 = 8'h10;
	localparam logic [7:0] OFS_PRESET2 = 8'h14;
	localparam logic [7:0] OFS_DUTY1   = 8'h18;
	localparam logic [7:0] OFS_FREQ1   = 8'h1C;
	localparam logic [7:0] OFS_DUTY2   = 8'h20;
	localparam logic [7:0] OFS_FREQ2   = 8'h24;
	localparam logic [7:0] OFS_SDUTY1  = 8'h28;
	localparam logic [7:0] OFS_SFREQ1  = 8'h2C;
	localparam logic [7:0] OFS_SDUTY2  = 8'h30;
	localparam logic [7:0] OFS_SFREQ2  = 8'h34;
	localparam logic [7:0] OFS_ACC1    = 8'h38;
	localparam logic [7:0] OFS_ACC2    = 8'h3C;
	localparam logic [7:0] OFS_ACC3    = 8'h40;
	localparam logic [7:0] OFS_ACC4    = 8'h44;
	localparam logic [31:0] REG_RESET  = 32'h0000_0000;
	// ****************
	// control register fields
	// ****************
	localparam int CTL_QUAD1_EN = 0;
	localparam int CTL_QUAD2_EN = 1;
	localparam int CTL_DIR1     = 2;
	localparam int CTL_DIR2     = 3;
	localparam int CTL_MARK_LSB = 4;
	localparam int CTL_OUT1_LSB = 8;
	localparam int CTL_OUT2_LSB = 10;
	localparam int CTL_PWM1_EN  = 12;
	localparam int CTL_PWM2_EN  = 13;
	localparam int CTL_STOP     = 14;
	localparam int CTL_HOLD1    = 15;
	localparam int CTL_HOLD2    = 16;
	// ladder bits
	localparam int LAD_OUT1 = 0;
	localparam int LAD_OUT2 = 1;
	localparam int LAD_CLR1 = 2;
	localparam int LAD_SET1 = 3;
	localparam int LAD_CLR2 = 4;
	localparam int LAD_SET2 = 5;
	// marker mode bits: sync, low level, input two, reset on falling
	localparam int MK_SYNC = 3;
	localparam int MK_LOW  = 2;
	localparam int MK_IN2  = 1;
	localparam int MK_FALL = 0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ****************
	// types
	// ****************
	typedef enum logic [1:0] {
		OUT_DIGITAL, OUT_PWM, OUT_COMPARE, OUT_OFF
	} qmp_outsel_type;
	typedef struct packed {
		logic        enable;
		logic        dir_up;
		logic        mark_en;
		logic [3:0]  mark_mode;
		logic [31:0] wrap;
		logic        clear;
		logic        set;
	} qmp_cnt_cfg_type;
endpackage

// ===== core/qmp_quad_counter.sv
// qmp_quad_counter: one quadrature accumulator with wrap and marker
`timescale 1ns/1ps
`default_nettype none
module qmp_quad_counter (
	// clock and reset
	input  wire logic                     i_mclk,
	input  wire logic                     i_reset_n,
	// synchronised levels
	input  wire logic                     i_chan_a,
	input  wire logic                     i_chan_b,
	input  wire logic                     i_marker,
	// configuration
	input  wire qmp_pkg::qmp_cnt_cfg_type i_cfg,
	// accumulator
	output logic [31:0]                   o_count
);
	logic        a_q;
	logic        b_q;
	logic        mk_q;
	logic        primed;
	logic        a_chg;
	logic        b_chg;
	logic        step;
	logic        up;
	logic        async_ev;
	logic        sync_ev;
	logic        sync_zero;
	logic [31:0] top;
	logic [3:0]  mode;

	// no edges before the first sampled level is known
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
			mk_q <= 1'b0;
			primed <= 1'b0;
		end else begin
			a_q <= i_chan_a;
			b_q <= i_chan_b;
			mk_q <= i_marker;
			primed <= 1'b1;
		end
	end

	assign mode = i_cfg.mark_mode;
	assign top = i_cfg.wrap - 32'h0000_0001;
	assign a_chg = a_q ^ i_chan_a;
	assign b_chg = b_q ^ i_chan_b;
	// both inputs moving at once has no direction: ignored
	assign step = i_cfg.enable & primed & (a_chg ^ b_chg);
	assign up = (a_chg ? (i_chan_a ^ i_chan_b) : ~(i_chan_a ^ i_chan_b))
		^ ~i_cfg.dir_up;
	assign async_ev = i_cfg.mark_en & primed & ~mode[qmp_pkg::MK_SYNC]
		& ((mode[0] & i_marker & ~mk_q)
		| (mode[1] & ~i_marker & mk_q));
	assign sync_ev = i_cfg.mark_en & mode[qmp_pkg::MK_SYNC] & step
		& (mode[qmp_pkg::MK_IN2] ? b_chg : a_chg)
		& (i_marker ^ mode[qmp_pkg::MK_LOW]);
	// forward edge is rising, reverse edge falling on the same spot
	assign sync_zero = (mode[qmp_pkg::MK_IN2] ? i_chan_b : i_chan_a)
		^ mode[qmp_pkg::MK_FALL];

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_count <= 32'h0000_0000;
		end else if (i_cfg.clear) begin
			o_count <= 32'h0000_0000;
		end else if (i_cfg.set) begin
			o_count <= top;
		end else if (async_ev) begin
			o_count <= 32'h0000_0000;
		end else if (sync_ev) begin
			o_count <= sync_zero ? 32'h0000_0000 : top;
		end else if (step && up) begin
			if (i_cfg.wrap != 32'h0000_0000 && o_count == top) begin
				o_count <= 32'h0000_0000;
			end else begin
				o_count <= o_count + 32'h0000_0001;
			end
		end else if (step) begin
			o_count <= (o_count == 32'h0000_0000) ? top
				: o_count - 32'h0000_0001;
		end
	end

	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	a_wrap_up: assert property (step && up && !i_cfg.clear && !i_cfg.set
		&& !async_ev && !sync_ev && i_cfg.wrap != 32'h0000_0000
		&& o_count == top |=> o_count == 32'h0000_0000)
		else $error("no wrap to zero");
	a_wrap_down: assert property (step && !up && !i_cfg.clear
		&& !i_cfg.set && !async_ev && !sync_ev
		&& o_count == 32'h0000_0000 |=> o_count == $past(top))
		else $error("no wrap to top");
	a_clear_hold: assert property (i_cfg.clear [*2]
		|-> o_count == 32'h0000_0000)
		else $error("clear not held");
	a_set_load: assert property (i_cfg.set && !i_cfg.clear
		|=> o_count == $past(top))
		else $error("set not loaded");
	a_async_mark: assert property (async_ev && !i_cfg.clear
		&& !i_cfg.set |=> o_count == 32'h0000_0000)
		else $error("marker clear lost");
	a_sync_mark: assert property (sync_ev && !i_cfg.clear
		&& !i_cfg.set |=> o_count == ($past(sync_zero)
		? 32'h0000_0000 : $past(top)))
		else $error("sync marker value wrong");
endmodule
`default_nettype wire

// ===== core/qmp_marker_counter_pwm.sv
// qmp_marker_counter_pwm: quadrature counters, compare and pwm outputs
`timescale 1ns/1ps
`default_nettype none
// Function
// - counting up, reaching wrap setting returns accumulator to zero.
// - counting down past zero loads wrap setting minus one.
// - wrap setting zero lets the full 32-bit range roll over.
// - clear bits force counter one or two to zero.
// - set bits load counter one or two with wrap minus one.
// - marker on channel three only while channels one, two are quad.
// - sync marker acts on chosen quadrature edge at chosen level.
// - marker sampled within 50 us of its quadrature edge.
// - reversed rotation on the same edge loads wrap minus one.
// - reset-on-rising: rising loads zero, falling loads wrap minus one.
// - reset-on-falling: rising loads wrap minus one, falling zero.
// - every sync mode has high and low marker level variants.
// - each output is digital, pwm, counter compare or off (held low).
// - compare output compares its counter with its preset.
// - digital mode output follows its control-program bit.
// - two pwm channels, separate enable, frequency and duty.
// - duty 0 to 32000; 0 holds off, 32000 holds on.
// - frequency in hertz; period is its reciprocal.
// - pwm stays low until frequency and duty are both non-zero.
// - in stop, pwm holds last state or runs stop settings.
// - decoder counts every edge of both inputs, four per cycle.
// - option picks up or down count when input one leads.
// - compare high at count at or above preset; zero preset low.
module qmp_marker_counter_pwm (
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_reset_n,
	// axi4-lite write
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	// axi4-lite read
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	// encoder pins
	input  wire logic [3:0]  i_fast_input_channel,
	// dedicated outputs
	output logic             o_dedicated_output_one,
	output logic             o_dedicated_output_two
);
	logic [3:0]               chan_s1;
	logic [3:0]               chan_s2;
	logic [31:0]              ctrl;
	logic [31:0]              ladder;
	logic [31:0]              wrap [2];
	logic [31:0]              preset [2];
	logic [31:0]              duty [2];
	logic [31:0]              freq [2];
	logic [31:0]              sduty [2];
	logic [31:0]              sfreq [2];
	logic [31:0]              acc [2];
	logic [31:0]              phase [2];
	logic [1:0]               pwm_q;
	logic [1:0]               cmp;
	logic [7:0]               aw_addr_q;
	logic [31:0]              w_data_q;
	logic [3:0]               w_strb_q;
	logic                     wr_fire;
	qmp_pkg::qmp_cnt_cfg_type cfg [2];

	// ****************
	// helpers
	// ****************
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= qmp_pkg::OFS_ACC4;
	endfunction

	// phase accumulator: rolls over once per second per hertz of frequency
	function automatic logic [31:0] next_phase(input logic [31:0] p,
		input logic [31:0] f);
		logic [32:0] s;
		s = {1'b0, p} + {1'b0, f};
		if (f >= 32'(qmp_pkg::CLK_HZ)) begin
			return 32'h0000_0000;
		end else if (s >= 33'(qmp_pkg::CLK_HZ)) begin
			return 32'(s - 33'(qmp_pkg::CLK_HZ));
		end
		return s[31:0];
	endfunction

	function automatic logic duty_high(input logic [31:0] p,
		input logic [31:0] d);
		logic [31:0] c;
		c = (d > 32'(qmp_pkg::DUTY_FULL)) ? 32'(qmp_pkg::DUTY_FULL) : d;
		return p < c * 32'(qmp_pkg::DUTY_SCALE);
	endfunction

	// ****************
	// pin synchroniser
	// ****************
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			chan_s1 <= 4'h0;
			chan_s2 <= 4'h0;
		end else begin
			chan_s1 <= i_fast_input_channel;
			chan_s2 <= chan_s1;
		end
	end

	// ****************
	// counters
	// ****************
	always_comb begin
		cfg[0].enable = ctrl[qmp_pkg::CTL_QUAD1_EN];
		cfg[0].dir_up = ctrl[qmp_pkg::CTL_DIR1];
		// channel three belongs to counter two when that one runs
		cfg[0].mark_en = ctrl[qmp_pkg::CTL_QUAD1_EN]
			& ~ctrl[qmp_pkg::CTL_QUAD2_EN];
		cfg[0].mark_mode = ctrl[qmp_pkg::CTL_MARK_LSB +: 4];
		cfg[0].wrap = wrap[0];
		cfg[0].clear = ladder[qmp_pkg::LAD_CLR1];
		cfg[0].set = ladder[qmp_pkg::LAD_SET1];
		cfg[1].enable = ctrl[qmp_pkg::CTL_QUAD2_EN];
		cfg[1].dir_up = ctrl[qmp_pkg::CTL_DIR2];
		cfg[1].mark_en = 1'b0;
		cfg[1].mark_mode = 4'h0;
		cfg[1].wrap = wrap[1];
		cfg[1].clear = ladder[qmp_pkg::LAD_CLR2];
		cfg[1].set = ladder[qmp_pkg::LAD_SET2];
	end

	qmp_quad_counter u_quad1 (
		.i_mclk    (i_mclk),
		.i_reset_n (i_reset_n),
		.i_chan_a  (chan_s2[0]),
		.i_chan_b  (chan_s2[1]),
		.i_marker  (chan_s2[2]),
		.i_cfg     (cfg[0]),
		.o_count   (acc[0])
	);

	qmp_quad_counter u_quad2 (
		.i_mclk    (i_mclk),
		.i_reset_n (i_reset_n),
		.i_chan_a  (chan_s2[2]),
		.i_chan_b  (chan_s2[3]),
		.i_marker  (1'b0),
		.i_cfg     (cfg[1]),
		.o_count   (acc[1])
	);

	// ****************
	// axi4-lite slave
	// ****************
	assign wr_fire = ~o_awready & ~o_wready & ~o_bvalid;

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_awready <= 1'b1;
			o_wready <= 1'b1;
			o_bvalid <= 1'b0;
			o_bresp <= qmp_pkg::RESP_OKAY;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_addr_q <= i_awaddr;
				o_awready <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_data_q <= i_wdata;
				w_strb_q <= i_wstrb;
				o_wready <= 1'b0;
			end
			if (wr_fire) begin
				o_bvalid <= 1'b1;
				o_bresp <= addr_ok(aw_addr_q) ? qmp_pkg::RESP_OKAY
					: qmp_pkg::RESP_SLVERR;
			end
			if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
				o_awready <= 1'b1;
				o_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl <= qmp_pkg::REG_RESET;
			ladder <= qmp_pkg::REG_RESET;
			for (int i = 0; i < 2; i++) begin
				wrap[i] <= qmp_pkg::REG_RESET;
				preset[i] <= qmp_pkg::REG_RESET;
				duty[i] <= qmp_pkg::REG_RESET;
				freq[i] <= qmp_pkg::REG_RESET;
				sduty[i] <= qmp_pkg::REG_RESET;
				sfreq[i] <= qmp_pkg::REG_RESET;
			end
		end else if (wr_fire) begin
			if (aw_addr_q == qmp_pkg::OFS_CTRL) begin
				ctrl <= merge(ctrl, w_data_q, w_strb_q);
			end else if (aw_addr_q == qmp_pkg::OFS_LADDER) begin
				ladder <= merge(ladder, w_data_q, w_strb_q);
			end else if (aw_addr_q == qmp_pkg::OFS_WRAP1) begin
				wrap[0] <= merge(wrap[0], w_data_q, w_strb_q);
			end else if (aw_addr_q == qmp_pkg::OFS_WRAP2) begin
				wrap[1] <= merge(wrap[1], w_data_q, w_strb_q);
			end else if (aw_addr_q == qmp_pkg::OFS_PRESET1) begin
				preset[0] <= merge(preset[0], w_data_q, w_strb_q);
			end else if (aw_addr_q == qmp_pkg::OFS_PRESET2) begin
				preset[1] <= merge(preset[1], w_data_q, w_strb_q);
			end else if (aw_addr_q == qmp_pkg::OFS_DUTY1) begin
				duty[0] <= merge(duty[0], w_data_q, w_strb_q);
			end else if (aw_addr_q == qmp_pkg::OFS_FREQ1) begin
				freq[0] <= merge(freq[0], w_data_q, w_strb_q);
			end else if (aw_addr_q == qmp_pkg::OFS_DUTY2) begin
				duty[1] <= merge(duty[1], w_data_q, w_strb_q);
			end else if (aw_addr_q == qmp_pkg::OFS_FREQ2) begin
				freq[1] <= merge(freq[1], w_data_q, w_strb_q);
			end else if (aw_addr_q == qmp_pkg::OFS_SDUTY1) begin
				sduty[0] <= merge(sduty[0], w_data_q, w_strb_q);
			end else if (aw_addr_q == qmp_pkg::OFS_SFREQ1) begin
				sfreq[0] <= merge(sfreq[0], w_data_q, w_strb_q);
			end else if (aw_addr_q == qmp_pkg::OFS_SDUTY2) begin
				sduty[1] <= merge(sduty[1], w_data_q, w_strb_q);
			end else if (aw_addr_q == qmp_pkg::OFS_SFREQ2) begin
				sfreq[1] <= merge(sfreq[1], w_data_q, w_strb_q);
			end
		end
	end

	function automatic logic [31:0] reg_read(input logic [7:0] a);
		if (a == qmp_pkg::OFS_CTRL) begin
			return ctrl;
		end else if (a == qmp_pkg::OFS_LADDER) begin
			return ladder;
		end else if (a == qmp_pkg::OFS_WRAP1) begin
			return wrap[0];
		end else if (a == qmp_pkg::OFS_WRAP2) begin
			return wrap[1];
		end else if (a == qmp_pkg::OFS_PRESET1) begin
			return preset[0];
		end else if (a == qmp_pkg::OFS_PRESET2) begin
			return preset[1];
		end else if (a == qmp_pkg::OFS_DUTY1) begin
			return duty[0];
		end else if (a == qmp_pkg::OFS_FREQ1) begin
			return freq[0];
		end else if (a == qmp_pkg::OFS_DUTY2) begin
			return duty[1];
		end else if (a == qmp_pkg::OFS_FREQ2) begin
			return freq[1];
		end else if (a == qmp_pkg::OFS_SDUTY1) begin
			return sduty[0];
		end else if (a == qmp_pkg::OFS_SFREQ1) begin
			return sfreq[0];
		end else if (a == qmp_pkg::OFS_SDUTY2) begin
			return sduty[1];
		end else if (a == qmp_pkg::OFS_SFREQ2) begin
			return sfreq[1];
		end else if (a == qmp_pkg::OFS_ACC1) begin
			return acc[0];
		end else if (a == qmp_pkg::OFS_ACC3) begin
			return acc[1];
		end
		// totalizer accumulators two and four are not built: read zero
		return 32'h0000_0000;
	endfunction

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_arready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= qmp_pkg::RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b1;
			o_rdata <= reg_read(i_araddr);
			o_rresp <= addr_ok(i_araddr) ? qmp_pkg::RESP_OKAY
				: qmp_pkg::RESP_SLVERR;
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	// ****************
	// pwm
	// ****************
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pwm_q <= 2'h0;
			phase[0] <= 32'h0000_0000;
			phase[1] <= 32'h0000_0000;
		end else begin
			for (int i = 0; i < 2; i++) begin
				logic        stop;
				logic [31:0] f;
				logic [31:0] d;
				logic [31:0] p;
				stop = ctrl[qmp_pkg::CTL_STOP];
				f = stop ? sfreq[i] : freq[i];
				d = stop ? sduty[i] : duty[i];
				p = next_phase(phase[i], f);
				if (stop && ctrl[qmp_pkg::CTL_HOLD1 + i]) begin
					pwm_q[i] <= pwm_q[i];
				end else if (!ctrl[qmp_pkg::CTL_PWM1_EN + i]
					|| f == 32'h0000_0000 || d == 32'h0000_0000) begin
					pwm_q[i] <= 1'b0;
					phase[i] <= 32'h0000_0000;
				end else begin
					phase[i] <= p;
					pwm_q[i] <= duty_high(p, d);
				end
			end
		end
	end

	// ****************
	// output stage
	// ****************
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			cmp[i] = preset[i] != 32'h0000_0000
				&& acc[i] >= preset[i];
		end
	end

	function automatic logic out_sel(input logic [1:0] sel,
		input logic dig, input logic pwm, input logic cm);
		case (qmp_pkg::qmp_outsel_type'(sel))
			qmp_pkg::OUT_DIGITAL: return dig;
			qmp_pkg::OUT_PWM: return pwm;
			qmp_pkg::OUT_COMPARE: return cm;
			default: return 1'b0;
		endcase
	endfunction

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_dedicated_output_one <= 1'b0;
			o_dedicated_output_two <= 1'b0;
		end else begin
			o_dedicated_output_one <= out_sel(
				ctrl[qmp_pkg::CTL_OUT1_LSB +: 2],
				ladder[qmp_pkg::LAD_OUT1], pwm_q[0], cmp[0]);
			o_dedicated_output_two <= out_sel(
				ctrl[qmp_pkg::CTL_OUT2_LSB +: 2],
				ladder[qmp_pkg::LAD_OUT2], pwm_q[1], cmp[1]);
		end
	end

	// ****************
	// checks
	// ****************
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	initial a_mark_budget: assert (3 < qmp_pkg::MARK_WIN_CYC)
		else $error("marker latency over budget");
	a_mark_window: assert property ($stable(i_fast_input_channel[2]) [*3]
		|-> chan_s2[2] == i_fast_input_channel[2])
		else $error("marker sample too late");
	a_cmp_out: assert property (ctrl[9:8] == 2'h2
		|=> o_dedicated_output_one == $past(cmp[0]))
		else $error("compare output wrong");
	a_dig_follow: assert property (ctrl[11:10] == 2'h0
		|=> o_dedicated_output_two == $past(ladder[qmp_pkg::LAD_OUT2]))
		else $error("digital output not following");
	a_pwm_zero: assert property (!ctrl[qmp_pkg::CTL_STOP]
		&& duty[0] == 32'h0000_0000 |=> !pwm_q[0])
		else $error("pwm high with zero duty");
	a_pwm_full: assert property (!ctrl[qmp_pkg::CTL_STOP]
		&& ctrl[qmp_pkg::CTL_PWM1_EN] && freq[0] != 32'h0000_0000
		&& duty[0] >= 32'(qmp_pkg::DUTY_FULL) |=> pwm_q[0])
		else $error("pwm low at full duty");
	a_pwm_hold: assert property (ctrl[qmp_pkg::CTL_STOP]
		&& ctrl[qmp_pkg::CTL_HOLD2] |=> $stable(pwm_q[1]))
		else $error("pwm not held in stop");
endmodule
`default_nettype wire

// ===== tb/qmp_encoder_model.sv
// qmp_encoder_model: incremental encoder with a, b and marker outputs
`timescale 1ns/1ps
`default_nettype none
module qmp_encoder_model (
	// clock
	input  wire logic i_mclk,
	// motion commands from the bench
	input  wire logic i_step,
	input  wire logic i_cw,
	input  wire logic i_mark,
	// encoder pins
	output logic [3:0] o_pins
);
	logic [1:0] phase = 2'h0;
	// ****************
	// one quadrature state per step
	// ****************
	always @(posedge i_mclk) begin
		if (i_step) begin
			phase <= i_cw ? phase + 2'h1 : phase - 2'h1;
		end
	end
	// gray order, a leads b clockwise; marker on channel three, channel four left idle
	// marker pin follows the bench mark command unchanged, in the same cycle
	assign o_pins = {1'b0, i_mark, phase[1], phase[0] ^ phase[1]};
endmodule
`default_nettype wire

// ===== tb/qmp_marker_counter_pwm_test.sv
// qmp_marker_counter_pwm_test: bench for counters, compare and pwm
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
	$display("BAD %0t %h %h", $time, (a), (b)); end end
module qmp_marker_counter_pwm_test;
	logic        i_mclk = 1'b0;
	logic        i_reset_n = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        step = 1'b0;
	logic        cw = 1'b0;
	logic        mark = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, out1, out2;
	logic [1:0]  bresp, rresp, rs;
	logic [31:0] rdata, rd;
	logic [3:0]  pins;
	int          err_total = 0;
	int          n_checks = 0;
	int          h;
	localparam logic [1:0] OK = qmp_pkg::RESP_OKAY;
	always #12.5 i_mclk = ~i_mclk;
	qmp_encoder_model enc (.i_mclk(i_mclk), .i_step(step), .i_cw(cw),
		.i_mark(mark), .o_pins(pins));
	qmp_marker_counter_pwm dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
		.i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
		.i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
		.o_rvalid(rvalid), .i_rready(rready),
		.i_fast_input_channel(pins), .o_dedicated_output_one(out1),
		.o_dedicated_output_two(out2));
	// ****************
	// bus and motion helpers
	// ****************
	task automatic close_out();
		if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge i_mclk);
			n++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 100);
		if (bvalid !== 1'b1) begin
			err_total++;
			close_out();
		end
		bready <= 1'b0;
		`CHK(bresp, r)
	endtask
	task automatic rdr(input logic [7:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge i_mclk);
			n++;
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 100);
		if (rvalid !== 1'b1) begin
			err_total++;
			close_out();
		end
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	task automatic acc(input logic [31:0] e);
		rdr(qmp_pkg::OFS_ACC1);
		`CHK(rd, e)
	endtask
	// steps spaced five clocks so each edge is counted
	task automatic mv(input logic dir, input int n);
		repeat (n) begin
			cw <= dir;
			step <= 1'b1;
			@(posedge i_mclk);
			step <= 1'b0;
			tick(4);
		end
	endtask
	task automatic hi_count();
		h = 0;
		repeat (400) begin
			@(posedge i_mclk);
			h += (out2 === 1'b1);
		end
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_reset();
		acc(qmp_pkg::REG_RESET);
		rdr(8'h48);
		`CHK(rs, qmp_pkg::RESP_SLVERR)
		wr(8'h4C, 32'h0000_0001, qmp_pkg::RESP_SLVERR);
	endtask
	task automatic t_count();
		wr(qmp_pkg::OFS_WRAP1, 32'h0000_0004, OK);
		wr(qmp_pkg::OFS_CTRL, 32'h0000_0205, OK);
		tick(2);
		`CHK(out1, 1'b0)
		wr(qmp_pkg::OFS_PRESET1, 32'h0000_0003, OK);
		mv(1'b1, 3);
		acc(32'h0000_0003);
		tick(2);
		`CHK(out1, 1'b1)
		mv(1'b1, 2);
		acc(32'h0000_0001);
		`CHK(out1, 1'b0)
		mv(1'b0, 2);
		acc(32'h0000_0003);
	endtask
	task automatic t_ladder();
		wr(qmp_pkg::OFS_LADDER, 32'h0000_0004, OK);
		acc(32'h0000_0000);
		mv(1'b1, 1);
		acc(32'h0000_0000);
		wr(qmp_pkg::OFS_LADDER, 32'h0000_0008, OK);
		acc(32'h0000_0003);
		wr(qmp_pkg::OFS_LADDER, 32'h0000_0004, OK);
		wr(qmp_pkg::OFS_WRAP1, 32'h0000_0000, OK);
		wr(qmp_pkg::OFS_LADDER, 32'h0000_0000, OK);
		mv(1'b0, 1);
		acc(32'hFFFF_FFFF);
	endtask
	// encoder now rests in phase three
	task automatic t_marker();
		wr(qmp_pkg::OFS_WRAP1, 32'h0000_0008, OK);
		wr(qmp_pkg::OFS_CTRL, 32'h0000_0215, OK);
		mark <= 1'b1;
		tick(5);
		acc(32'h0000_0000);
		mark <= 1'b0;
		wr(qmp_pkg::OFS_CTRL, 32'h0000_0285, OK);
		// five steps leave the next one as a rising a edge
		mv(1'b1, 5);
		mark <= 1'b1;
		mv(1'b1, 1);
		acc(32'h0000_0000);
		mark <= 1'b0;
		// full cycle so the reverse edge starts from a non-zero count
		mv(1'b1, 4);
		mark <= 1'b1;
		mv(1'b0, 1);
		acc(32'h0000_0007);
		wr(qmp_pkg::OFS_CTRL, 32'h0000_02F5, OK);
		mv(1'b1, 1);
		mark <= 1'b0;
		mv(1'b1, 1);
		acc(32'h0000_0007);
		wr(qmp_pkg::OFS_CTRL, 32'h0000_0217, OK);
		mark <= 1'b1;
		tick(5);
		acc(32'h0000_0007);
		mark <= 1'b0;
	endtask
	task automatic t_outputs();
		wr(qmp_pkg::OFS_DUTY2, 32'h0000_1F40, OK);
		wr(qmp_pkg::OFS_FREQ2, 32'h000F_4240, OK);
		wr(qmp_pkg::OFS_CTRL, 32'h0000_2401, OK);
		wr(qmp_pkg::OFS_LADDER, 32'h0000_0001, OK);
		tick(50);
		`CHK(out1, 1'b1)
		hi_count();
		`CHK(h, 100)
		wr(qmp_pkg::OFS_DUTY2, 32'h0000_0000, OK);
		tick(50);
		hi_count();
		`CHK(h, 0)
		wr(qmp_pkg::OFS_DUTY2, 32'h0000_7D00, OK);
		wr(qmp_pkg::OFS_CTRL, 32'h0001_6401, OK);
		hi_count();
		`CHK(h, 400)
		wr(qmp_pkg::OFS_CTRL, 32'h0000_6401, OK);
		tick(2);
		hi_count();
		`CHK(h, 0)
		wr(qmp_pkg::OFS_DUTY1, 32'h0000_7D00, OK);
		wr(qmp_pkg::OFS_FREQ1, 32'h0000_0001, OK);
		wr(qmp_pkg::OFS_CTRL, 32'h0000_1101, OK);
		tick(2);
		`CHK(out1, 1'b1)
		`CHK(out2, 1'b0)
	endtask
	initial begin
		tick(8);
		i_reset_n <= 1'b1;
		tick(1);
		t_reset();
		t_count();
		t_ladder();
		t_marker();
		t_outputs();
		close_out();
	end
endmodule
`default_nettype wire
